// [drc_map.vh]
`ifndef DRC_MAP_VH
`define DRC_MAP_VH
// Frame and command layout
`define DRC_FRAME_BITS 24
`define DRC_CODE_BITS 12
`define DRC_CMD_REF_OFF 24'h012000
`define DRC_CMD_REF_ON 24'h011000
`define DRC_CMD_REF_AUTO 24'h010000
// Reference modes
`define DRC_MODE_AUTO 2'h0
`define DRC_MODE_OFF 2'h1
`define DRC_MODE_ON 2'h2
`define DRC_MODE_RESET 2'h0
`define DRC_REF_POWER_RESET 1'b1
// Code mapping points
`define DRC_CODE_MID 12'h800
`define DRC_CODE_FULL 12'hFFF
`endif

// [drc_frame_rx.v]
`timescale 1ns/10ps
`include "drc_map.vh"
module drc_frame_rx (
	// Clock and reset
	input wire i_sys_clk,
	input wire i_reset_n,
	// Serial pins
	input wire i_frame_sel_n,
	input wire i_ser_clk,
	input wire i_ser_data,
	// Frame out
	output reg [23:0] o_frame_ff,
	output reg o_frame_done_ff
);
	reg [2:0] sel_sync_ff;
	reg [2:0] clk_sync_ff;
	reg [1:0] dat_sync_ff;
	reg [23:0] shift_ff;
	reg [4:0] count_ff;
	wire sel_n;
	wire fall_edge;
	assign sel_n = sel_sync_ff[1];
	// Falling serial clock seen after two stages
	assign fall_edge = clk_sync_ff[2] & ~clk_sync_ff[1];

	// Pin synchronisers
	always @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sel_sync_ff <= 3'h7;
			clk_sync_ff <= 3'h0;
			dat_sync_ff <= 2'h0;
		end else begin
			sel_sync_ff <= {sel_sync_ff[1:0], i_frame_sel_n};
			clk_sync_ff <= {clk_sync_ff[1:0], i_ser_clk};
			dat_sync_ff <= {dat_sync_ff[0], i_ser_data};
		end
	end

	// MSB-first shift, lock after last bit
	always @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			shift_ff <= 24'h000000;
			count_ff <= 5'h00;
			o_frame_ff <= 24'h000000;
			o_frame_done_ff <= 1'b0;
		end else begin
			o_frame_done_ff <= 1'b0;
			if (sel_n) begin
				count_ff <= 5'h00; // Early rise aborts frame
			end else if (fall_edge && count_ff < `DRC_FRAME_BITS) begin
				shift_ff <= {shift_ff[22:0], dat_sync_ff[1]};
				count_ff <= count_ff + 5'h01;
				if (count_ff == `DRC_FRAME_BITS - 1) begin
					o_frame_ff <= {shift_ff[22:0], dat_sync_ff[1]};
					o_frame_done_ff <= 1'b1;
				end
			end
		end
	end
endmodule

// [drc_code_map.v]
`timescale 1ns/10ps
`include "drc_map.vh"
module drc_code_map #(
	parameter W = 12
) (
	// Code in
	input wire [W-1:0] i_code,
	input wire i_twos_complement_code,
	// Count out
	output wire [W-1:0] o_count
);
	// Two's complement maps to offset binary by MSB flip
	assign o_count = {i_code[W-1] ^ i_twos_complement_code, i_code[W-2:0]};
endmodule

// [drc_top.v]
`timescale 1ns/10ps
`include "drc_map.vh"
module drc_top #(
	parameter CH = 4,
	parameter W = `DRC_CODE_BITS
) (
	// Clock and reset
	input wire i_sys_clk,
	input wire i_reset_n,
	// Serial pins
	input wire i_frame_sel_n,
	input wire i_ser_clk,
	input wire i_ser_data,
	// Channel side
	input wire i_twos_complement_code,
	input wire [CH-1:0] i_chan_powered_dn,
	input wire i_code_load,
	input wire [1:0] i_code_chan,
	input wire [W-1:0] i_code,
	// Outputs
	output reg [W*CH-1:0] o_counts_ff,
	output reg o_ref_power_ff,
	output reg o_ref_pin_oe_ff,
	output reg [1:0] o_ref_mode_ff,
	output reg [23:0] o_last_frame_ff,
	output reg o_frame_done_ff
);
	// Block overview
	// Serial command frames arrive on three slow pins
	// Pins pass the receiver's own two-stage synchronisers
	// Receiver hands over one 24-bit word per complete frame
	// Short frames are dropped inside the receiver
	// Bits past the 24th are ignored until select rises
	// Only three frame values touch the reference mode
	// Every other frame leaves the mode alone
	// Channel codes load through a separate strobe
	// Code mapping is purely combinational
	// Converter registers and the last frame capture are the data storage
	// Reference power is a single registered decision
	// Pin drive enable shares that same decision
	// All outputs come straight from flip-flops

	// Timing summary
	// Falling serial clock seen about two cycles late
	// Frame word ready one cycle after the last bit
	// Mode and power settle on the following edge
	// Frame done pulse lines up with the mode change
	// Channel power changes reach the reference in three cycles

	// Limitations
	// Serial clock must stay slow against the system clock
	// Each serial clock level needs several system cycles
	// Channel index wider than two bits is not decoded
	// Unused mode code falls back to automatic

	// Reference modes as local state codes
	localparam [1:0] MODE_AUTO = `DRC_MODE_AUTO;
	localparam [1:0] MODE_OFF = `DRC_MODE_OFF;
	localparam [1:0] MODE_ON = `DRC_MODE_ON;

	// Frame receiver result
	wire [23:0] frame;
	wire frame_done;
	// Mapped converter count
	wire [W-1:0] count;
	// Command decode result
	wire [2:0] cmd_word;
	wire cmd_hit;
	wire [1:0] cmd_mode;
	// Channel power summary
	wire all_chan_dn;
	// Next state
	reg [1:0] nxt_mode;
	reg nxt_power;
	// Channel power synchronisers
	reg [CH-1:0] dn_s1_ff;
	reg [CH-1:0] dn_s2_ff;
	integer k;

	// Reference command decode, hit flag above mode code
	function [2:0] ref_cmd_decode;
		input [23:0] f;
		begin
			case (f)
				`DRC_CMD_REF_OFF: ref_cmd_decode = {1'b1, MODE_OFF};
				`DRC_CMD_REF_ON: ref_cmd_decode = {1'b1, MODE_ON};
				`DRC_CMD_REF_AUTO: ref_cmd_decode = {1'b1, MODE_AUTO};
				default: ref_cmd_decode = {1'b0, MODE_AUTO};
			endcase
		end
	endfunction

	// Reference power wanted for a mode and channel summary
	function ref_power_for;
		input [1:0] mode;
		input all_dn;
		begin
			case (mode)
				MODE_OFF: ref_power_for = 1'b0;
				MODE_ON: ref_power_for = 1'b1;
				default: ref_power_for = ~all_dn;
			endcase
		end
	endfunction

	// Channel index match for the load strobe
	function chan_match;
		input [1:0] sel;
		input integer idx;
		begin
			chan_match = (sel == idx[1:0]);
		end
	endfunction

	// Receiver notes
	// Receiver owns all serial pin synchronisation
	// Nothing here reads the raw serial pins
	// Frame word holds still between frames
	// Done pulse lasts exactly one cycle

	drc_frame_rx u_rx (
		.i_sys_clk(i_sys_clk),
		.i_reset_n(i_reset_n),
		.i_frame_sel_n(i_frame_sel_n),
		.i_ser_clk(i_ser_clk),
		.i_ser_data(i_ser_data),
		.o_frame_ff(frame),
		.o_frame_done_ff(frame_done)
	);

	drc_code_map #(.W(W)) u_map (
		.i_code(i_code),
		.i_twos_complement_code(i_twos_complement_code),
		.o_count(count)
	);

	// Power summary hazards
	// Channel states come from another domain
	// Two flops before the all-down reduction
	// Reduction of raw inputs could glitch the reference
	// Power flop follows one cycle after the summary
	// Pin enable shares the power decision
	// External reference must never fight the pin

	// Channel power states, two stages from analog side
	// Reset to powered up so the reference starts enabled
	always @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			dn_s1_ff <= {CH{1'b0}};
			dn_s2_ff <= {CH{1'b0}};
		end else begin
			dn_s1_ff <= i_chan_powered_dn;
			dn_s2_ff <= dn_s1_ff;
		end
	end

	// Channel power summary from second stage only
	assign all_chan_dn = &dn_s2_ff;

	// Command decode of the latest frame
	assign cmd_word = ref_cmd_decode(frame);
	assign cmd_hit = cmd_word[2];
	assign cmd_mode = cmd_word[1:0];

	// Mode notes
	// Automatic: power follows channel states
	// Forced off: power held low, pin released
	// Forced on: power held high always
	// Reset value is automatic with power on
	// Unknown frames change nothing
	// Short frames never reach the decode

	// Mode next state, complete recognised frames only
	always @* begin
		nxt_mode = o_ref_mode_ff;
		case (o_ref_mode_ff)
			MODE_AUTO, MODE_OFF, MODE_ON: begin
				if (frame_done && cmd_hit) begin
					nxt_mode = cmd_mode;
				end
			end
			default: nxt_mode = MODE_AUTO;
		endcase
	end

	// Reference power by mode
	always @* begin
		nxt_power = ref_power_for(nxt_mode, all_chan_dn);
	end

	// Mode, power and pin drive state
	always @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_ref_mode_ff <= `DRC_MODE_RESET;
			o_ref_power_ff <= `DRC_REF_POWER_RESET;
			o_ref_pin_oe_ff <= `DRC_REF_POWER_RESET;
		end else begin
			o_ref_mode_ff <= nxt_mode;
			o_ref_power_ff <= nxt_power;
			o_ref_pin_oe_ff <= nxt_power;
		end
	end

	// Last frame capture
	always @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_last_frame_ff <= 24'h000000;
			o_frame_done_ff <= 1'b0;
		end else begin
			o_frame_done_ff <= frame_done;
			if (frame_done) begin
				o_last_frame_ff <= frame;
			end
		end
	end

	// Converter register notes
	// One 12-bit count per channel
	// Counts are offset binary after mapping
	// Load strobe writes one channel per cycle
	// Reset clears every count to zero
	// Count held until the next load of that channel
	// Analog side reads counts directly

	// Converter registers hold 0..4095 counts
	always @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_counts_ff <= {W*CH{1'b0}};
		end else if (i_code_load) begin
			for (k = 0; k < CH; k = k + 1) begin
				if (chan_match(i_code_chan, k)) begin
					o_counts_ff[k*W +: W] <= count;
				end
			end
		end
	end
endmodule

// [drc_assertions.sv]
`timescale 1ns/10ps
module drc_chk #(parameter CH = 4) (
	// Clock, reset, channels
	input wire i_sys_clk,
	input wire i_reset_n,
	input wire [CH-1:0] i_chan_powered_dn,
	// Reference outputs
	input wire o_ref_power_ff,
	input wire o_ref_pin_oe_ff,
	input wire [1:0] o_ref_mode_ff,
	input wire [23:0] o_last_frame_ff,
	input wire o_frame_done_ff
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_reset_n);
	// Power against mode and channels
	a_pin_power: assert property (o_ref_pin_oe_ff == o_ref_power_ff) else $error("oe");
	a_off_dark: assert property (o_ref_mode_ff == 2'h1 |-> !o_ref_power_ff) else $error("off");
	a_on_lit: assert property (o_ref_mode_ff == 2'h2 |-> o_ref_power_ff) else $error("on");
	a_auto_down: assert property ((o_ref_mode_ff == 2'h0 && &i_chan_powered_dn) [*5]
		|-> !o_ref_power_ff) else $error("auto up");
	a_auto_up: assert property ((o_ref_mode_ff == 2'h0 && !(&i_chan_powered_dn)) [*5]
		|-> o_ref_power_ff) else $error("auto down");
	// Mode moves only on decoded frames
	a_mode_framed: assert property (!$stable(o_ref_mode_ff) |-> o_frame_done_ff) else $error("mode");
	a_on_decode: assert property (o_frame_done_ff && o_last_frame_ff == 24'h011000
		|-> o_ref_mode_ff == 2'h2) else $error("on cmd");
	a_off_decode: assert property (o_frame_done_ff && o_last_frame_ff == 24'h012000
		|-> o_ref_mode_ff == 2'h1) else $error("off cmd");
endmodule
bind drc_top drc_chk #(.CH(CH)) u_chk (.*);

// [drc_host.sv]
`timescale 1ns/10ps
module drc_host (
	// Clock in, serial pins out
	input wire i_sys_clk,
	output logic o_frame_sel_n,
	output logic o_ser_clk,
	output logic o_ser_data
);
	// Idle levels: select high, clock high
	initial begin
		o_frame_sel_n = 1'b1;
		o_ser_clk = 1'b1;
		o_ser_data = 1'b0;
	end
	// Step k edges, then just after
	task w(input integer k);
		repeat (k) @(posedge i_sys_clk);
		#1;
	endtask
	// Shift n bits MSB first; clock still outside frames
	task send(input [23:0] f, input integer n);
		integer i;
		o_frame_sel_n = 1'b0;
		for (i = 23; i > 23 - n; i--) begin
			o_ser_data = f[i];
			w(4);
			o_ser_clk = 1'b0;
			w(4);
			o_ser_clk = 1'b1;
		end
		w(4);
		o_frame_sel_n = 1'b1;
		o_ser_data = ~o_ser_data;
		w(8);
	endtask
endmodule

// [tb_dac_reference_and_code_control.sv]
`timescale 1ns/10ps
module tb_dac_reference_and_code_control;
	logic i_sys_clk, i_reset_n, i_twos_complement_code, i_code_load;
	logic [3:0] i_chan_powered_dn;
	logic [1:0] i_code_chan;
	logic [11:0] i_code;
	wire i_frame_sel_n, i_ser_clk, i_ser_data, o_ref_power_ff, o_ref_pin_oe_ff, o_frame_done_ff;
	wire [1:0] o_ref_mode_ff;
	wire [23:0] o_last_frame_ff;
	wire [47:0] o_counts_ff;
	integer err_count = 0;
	integer checks_done = 0;
	// Rows: format flag, code, count
	logic [24:0] rows [6] = '{25'h0FFFFFF, 25'h17FFFFF, 25'h0800800,
		25'h1000800, 25'h0000000, 25'h1800000};
	drc_top DUT (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_frame_sel_n(i_frame_sel_n),
		.i_ser_clk(i_ser_clk), .i_ser_data(i_ser_data),
		.i_twos_complement_code(i_twos_complement_code), .i_chan_powered_dn(i_chan_powered_dn),
		.i_code_load(i_code_load), .i_code_chan(i_code_chan), .i_code(i_code),
		.o_counts_ff(o_counts_ff), .o_ref_power_ff(o_ref_power_ff),
		.o_ref_pin_oe_ff(o_ref_pin_oe_ff), .o_ref_mode_ff(o_ref_mode_ff),
		.o_last_frame_ff(o_last_frame_ff), .o_frame_done_ff(o_frame_done_ff));
	drc_host u_host (.i_sys_clk(i_sys_clk), .o_frame_sel_n(i_frame_sel_n),
		.o_ser_clk(i_ser_clk), .o_ser_data(i_ser_data));
	initial begin
		i_sys_clk = 1'b0;
		forever #20 i_sys_clk = ~i_sys_clk;
	end
	// Compare and count
	task chk(input [47:0] s, input [47:0] e);
		checks_done++;
		if (s !== e) begin
			err_count++;
			$display("MISMATCH %0t seen %h want %h", $time, s, e);
		end
	endtask
	task final_report;
		if (err_count == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Watchdog
	initial begin
		#400000 err_count++;
		final_report;
	end
	// Main sequence
	initial begin
		i_reset_n = 1'b0;
		i_twos_complement_code = 1'b0;
		i_code_load = 1'b0;
		i_chan_powered_dn = 4'h0;
		i_code_chan = 2'h0;
		i_code = 12'h000;
		u_host.w(5);
		i_reset_n = 1'b1;
		u_host.w(5);
		chk({o_ref_mode_ff, o_ref_power_ff}, 3'h1);
		foreach (rows[k]) begin
			{i_twos_complement_code, i_code} = rows[k][24:12];
			i_code_chan = 2'(k);
			i_code_load = 1'b1;
			u_host.w(1);
			i_code_load = 1'b0;
			chk(o_counts_ff[k % 4 * 12 +: 12], rows[k][11:0]);
			u_host.w(1);
		end
		i_chan_powered_dn = 4'hF;
		u_host.w(6);
		chk(o_ref_power_ff, 1'b0);
		u_host.send(24'h012000, 24);
		chk({o_ref_mode_ff, o_ref_power_ff, o_ref_pin_oe_ff}, 4'h4);
		chk(o_last_frame_ff, 24'h012000);
		u_host.send(24'h011000, 23);
		chk(o_ref_mode_ff, 2'h1);
		u_host.send(24'h011000, 24);
		chk({o_ref_mode_ff, o_ref_power_ff}, 3'h5);
		u_host.send(24'h010000, 24);
		chk({o_ref_mode_ff, o_ref_power_ff}, 3'h0);
		i_chan_powered_dn = 4'hE;
		u_host.w(6);
		chk(o_ref_power_ff, 1'b1);
		u_host.send(24'h012000, 24);
		chk(o_ref_mode_ff, 2'h1);
		i_reset_n = 1'b0;
		u_host.w(2);
		i_reset_n = 1'b1;
		u_host.w(5);
		chk({o_ref_mode_ff, o_ref_power_ff}, 3'h1);
		final_report;
	end
endmodule
